// ==== hw/cst_pkg.sv ====
// How it works
// - synchronous mode flags pending, selects when ready
// - multi-byte slow transfers to byte ports run back-to-back
// - synchronous mode ignores wait-state field
// - pin field 10 byte ack, 11 word ack
// - pin field 00/01 still acks internally
// - byte acknowledge exists internally for pin field 00 and 10 only
// - transfer size decodes used data byte lanes
// - byte-lane field gates select on 16-bit ports
// - wait field 1110 selects four-clock fast termination
// - fast termination only for chip-select matches
// - fast cycles ack internally, skip S2 and S3
// - fast writes never assert data strobe
// - S0 of read drives address, code, size, read
// - S1 of read asserts both strobes, decodes lanes
// - S4 of read acks internally and latches data
// - S5 negates strobes, holds address and controls
// - fast write drives write in S0, address strobe only
// - S4 write data valid, internal ack; S5 holds
// - wait field counts wait states; 1111 waits external
// - first acknowledge, internal or external, ends cycle
// - chip-select output is active low
package cst_pkg;
  localparam logic [3:0] CST_WAIT_FAST = 4'he;
  localparam logic [3:0] CST_WAIT_EXT  = 4'hf;
  localparam logic [1:0] CST_BYTE_OFF  = 2'h0;
  localparam logic [1:0] CST_BYTE_LO   = 2'h1;
  localparam logic [1:0] CST_BYTE_HI   = 2'h2;
  localparam int         CST_BYTE_LO_BIT = 0;
  localparam int         CST_BYTE_HI_BIT = 1;
  localparam int         CST_PORT16_BIT  = 0;
  localparam logic [1:0] CST_SIZE_LONG = 2'h0;
  localparam logic [1:0] CST_SIZE_BYTE = 2'h1;
  localparam logic [2:0] CST_LONG_BYTES = 3'h4;
  localparam logic [23:0] CST_ADDR_RST = 24'h000000;
  localparam logic [15:0] CST_DATA_RST = 16'h0000;
  localparam logic [3:0]  CST_CNT_RST  = 4'h0;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_S0    = 4'h1,
    ST_S1    = 4'h2,
    ST_S2    = 4'h3,
    ST_SPEND = 4'h4,
    ST_SRUN  = 4'h5,
    ST_S4    = 4'h6,
    ST_S5    = 4'h7
  } cst_state_t;
endpackage

// ==== hw/cst_top.sv ====
module cst_top
  import cst_pkg::*;
#(
  parameter int AW = 24,
  parameter int DW = 16
) (
  input  wire logic          CLK_SYS,
  input  wire logic          ARST_N,
  input  wire logic          CPU_REQ,
  input  wire logic [AW-1:0] CPU_ADDR,
  input  wire logic [2:0]    CPU_FUNC_CODE,
  input  wire logic          CPU_READ,
  input  wire logic [1:0]    CPU_SIZE,
  input  wire logic [DW-1:0] CPU_WDATA,
  input  wire logic          CS_MATCH,
  input  wire logic [1:0]    PIN_FIELD,
  input  wire logic [3:0]    WAIT_FIELD,
  input  wire logic [1:0]    BYTE_FIELD,
  input  wire logic          SYNC_MODE,
  input  wire logic          STROBE_SELECT,
  input  wire logic          EXT_BYTE_ACK_N,
  input  wire logic          EXT_WORD_ACK_N,
  input  wire logic          SLOW_READY,
  input  wire logic          SLOW_DONE,
  input  wire logic [DW-1:0] DATA_IN,
  output logic [AW-1:0]      ADDR_OUT,
  output logic [2:0]         FUNC_CODE_OUT,
  output logic               READ_OUT,
  output logic [1:0]         SIZE_OUT,
  output logic               ADDRESS_STROBE_N,
  output logic               DATA_STROBE_N,
  output logic               CS_N,
  output logic               SLOW_PENDING,
  output logic               BYTE_ACK,
  output logic               WORD_ACK,
  output logic               LANE_UPPER,
  output logic               LANE_LOWER,
  output logic [DW-1:0]      DATA_OUT,
  output logic               DATA_OE,
  output logic [DW-1:0]      RD_DATA,
  output logic               CPU_DONE,
  output logic [3:0]         BUS_STATE
);

  cst_state_t      state_reg;
  cst_state_t      state_next;
  logic [AW-1:0]   addr_reg;
  logic [2:0]      func_reg;
  logic            read_reg;
  logic [1:0]      size_reg;
  logic [DW-1:0]   wdata_reg;
  logic [DW-1:0]   rdata_reg;
  logic            hit_reg;
  logic            hit_next;
  logic            int_ack_reg;
  logic            int_ack_next;
  logic [3:0]      cnt_reg;
  logic [3:0]      cnt_next;
  logic [2:0]      left_reg;
  logic [2:0]      left_next;
  logic            port16;
  logic            lane_ok;
  logic            ext_ack;
  logic            fast_sel;
  logic            strobe_on;
  logic            cs_on;
  logic [2:0]      bytes_total;

  assign port16   = PIN_FIELD[CST_PORT16_BIT];
  assign ext_ack  = ~EXT_BYTE_ACK_N | ~EXT_WORD_ACK_N;
  assign fast_sel = (WAIT_FIELD == CST_WAIT_FAST);

  // byte lanes from size and address bit 0
  assign LANE_UPPER = ~addr_reg[0];
  assign LANE_LOWER = addr_reg[0] | (size_reg != CST_SIZE_BYTE);

  // byte-lane field gating: field 00 blocks every port, lane bits apply to 16-bit ports only
  always_comb begin
    if (BYTE_FIELD == CST_BYTE_OFF) begin
      lane_ok = 1'b0;
    end else if (!port16) begin
      lane_ok = 1'b1;
    end else begin
      lane_ok = (BYTE_FIELD[CST_BYTE_LO_BIT] & ~addr_reg[0]) |
                (BYTE_FIELD[CST_BYTE_HI_BIT] &  addr_reg[0]);
    end
  end

  assign bytes_total = (size_reg == CST_SIZE_LONG) ? CST_LONG_BYTES : {1'b0, size_reg};

  always_comb begin
    state_next   = state_reg;
    hit_next     = hit_reg;
    int_ack_next = int_ack_reg;
    cnt_next     = cnt_reg;
    left_next    = left_reg;
    case (state_reg)
      ST_IDLE: begin
        if (CPU_REQ) begin
          state_next = ST_S0;
        end
      end
      ST_S0: begin
        state_next = ST_S1;
      end
      ST_S1: begin
        hit_next     = CS_MATCH & lane_ok;
        int_ack_next = 1'b0;
        cnt_next     = WAIT_FIELD;
        left_next    = port16 ? 3'h1 : bytes_total;
        if (CS_MATCH && lane_ok && SYNC_MODE) begin
          state_next = ST_SPEND;
        end else if (CS_MATCH && lane_ok && fast_sel) begin
          state_next   = ST_S4;
          int_ack_next = 1'b1;
        end else begin
          state_next = ST_S2;
        end
      end
      ST_S2: begin
        if (ext_ack) begin
          state_next = ST_S4;
        end else if (hit_reg && cnt_reg != CST_WAIT_EXT) begin
          if (cnt_reg == CST_CNT_RST) begin
            state_next   = ST_S4;
            int_ack_next = 1'b1;
          end else begin
            cnt_next = cnt_reg - 4'h1;
          end
        end
      end
      ST_SPEND: begin
        if (SLOW_READY) begin
          state_next = ST_SRUN;
        end
      end
      ST_SRUN: begin
        if (SLOW_DONE) begin
          if (left_reg > 3'h1) begin
            left_next = left_reg - 3'h1;
          end else begin
            state_next = ST_S4;
          end
        end
      end
      ST_S4: begin
        state_next = ST_S5;
      end
      ST_S5: begin
        state_next = CPU_REQ ? ST_S0 : ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg   <= ST_IDLE;
      hit_reg     <= 1'b0;
      int_ack_reg <= 1'b0;
      cnt_reg     <= CST_CNT_RST;
      left_reg    <= 3'h0;
    end else begin
      state_reg   <= state_next;
      hit_reg     <= hit_next;
      int_ack_reg <= int_ack_next;
      cnt_reg     <= cnt_next;
      left_reg    <= left_next;
    end
  end

  // address, code, direction and size captured in S0, held through S5
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      addr_reg  <= CST_ADDR_RST;
      func_reg  <= 3'h0;
      read_reg  <= 1'b1;
      size_reg  <= CST_SIZE_BYTE;
      wdata_reg <= CST_DATA_RST;
    end else if (state_next == ST_S0) begin
      addr_reg  <= CPU_ADDR;
      func_reg  <= CPU_FUNC_CODE;
      read_reg  <= CPU_READ;
      size_reg  <= CPU_SIZE;
      wdata_reg <= CPU_WDATA;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_reg <= CST_DATA_RST;
    end else if (state_reg == ST_S4 && read_reg) begin
      rdata_reg <= DATA_IN;
    end
  end

  assign ADDR_OUT      = addr_reg;
  assign FUNC_CODE_OUT = func_reg;
  assign READ_OUT      = read_reg;
  assign SIZE_OUT      = size_reg;
  assign DATA_OUT      = wdata_reg;
  assign RD_DATA       = rdata_reg;
  assign BUS_STATE     = state_reg;

  // strobes live from S1 until S5 negates them; data strobe on reads only
  assign strobe_on = (state_reg == ST_S1) || (state_reg == ST_S2) ||
                     (state_reg == ST_SPEND) || (state_reg == ST_SRUN) ||
                     (state_reg == ST_S4);
  assign ADDRESS_STROBE_N = ~strobe_on;
  assign DATA_STROBE_N    = ~(strobe_on & read_reg);
  assign DATA_OE          = (strobe_on | (state_reg == ST_S5)) & ~read_reg;

  // chip select: strobe-timed, or slow-clock timed once the interface is ready
  always_comb begin
    if (state_reg == ST_SRUN) begin
      cs_on = 1'b1;
    end else if (state_reg == ST_S1) begin
      cs_on = CS_MATCH & lane_ok & ~SYNC_MODE & (~STROBE_SELECT | read_reg);
    end else if (state_reg == ST_S2 || state_reg == ST_S4) begin
      cs_on = hit_reg & ~SYNC_MODE & (~STROBE_SELECT | read_reg);
    end else begin
      cs_on = 1'b0;
    end
  end
  assign CS_N = ~cs_on;

  assign SLOW_PENDING = (state_reg == ST_SPEND);
  assign BYTE_ACK = (state_reg == ST_S4) & int_ack_reg & ~port16;
  assign WORD_ACK = (state_reg == ST_S4) & int_ack_reg &  port16;
  assign CPU_DONE = (state_reg == ST_S5);

  sequence fast_start_s;
    state_reg == ST_S1 && CS_MATCH && lane_ok && !SYNC_MODE && fast_sel;
  endsequence

  sequence zero_wait_s;
    state_reg == ST_S1 && CS_MATCH && lane_ok && !SYNC_MODE &&
      WAIT_FIELD == 4'h0;
  endsequence

  fast_path_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    fast_start_s |=> state_reg == ST_S4 && (BYTE_ACK || WORD_ACK) ##1 CPU_DONE)
    else $error("fast cycle did not ack in S4");

  zero_wait_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    zero_wait_s and !ext_ack |=> state_reg == ST_S2 ##1 state_reg == ST_S4)
    else $error("zero wait cycle mistimed");

  miss_noack_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_S4 && !hit_reg |-> !BYTE_ACK && !WORD_ACK)
    else $error("internal ack without a match");

  port_size_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    BYTE_ACK || WORD_ACK |-> WORD_ACK == PIN_FIELD[0] && BYTE_ACK != WORD_ACK)
    else $error("ack does not follow port size");

  ext_end_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_S2 && ext_ack |=> state_reg == ST_S4 ##1 state_reg == ST_S5)
    else $error("external ack did not end cycle");

  sync_gate_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    SLOW_PENDING && !SLOW_READY |=> SLOW_PENDING && CS_N)
    else $error("select before slow ready");

  sync_noack_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_SRUN |=> !BYTE_ACK && !WORD_ACK)
    else $error("slow cycle used internal ack");

  write_nods_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !read_reg |-> DATA_STROBE_N)
    else $error("data strobe on a write");

  s5_hold_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_S4 |=> ADDRESS_STROBE_N && DATA_STROBE_N &&
      $stable(ADDR_OUT) && $stable(SIZE_OUT) && $stable(READ_OUT))
    else $error("S5 strobes or address wrong");

  read_latch_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_S4 && read_reg |=> RD_DATA == $past(DATA_IN))
    else $error("read data not latched in S4");

  byte_off_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_S1 && BYTE_FIELD == 2'h0 |=> !hit_reg && CS_N)
    else $error("disabled byte field selected");

  sequence sync_start_s;
    state_reg == ST_S1 && CS_MATCH && lane_ok && SYNC_MODE;
  endsequence

  sync_start_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    sync_start_s |=> SLOW_PENDING && CS_N)
    else $error("slow cycle selected before ready");

  slow_cs_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_SRUN |-> !CS_N)
    else $error("select dropped in slow cycle");

  slow_next_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_SRUN && SLOW_DONE && left_reg > 3'h1 |=>
      state_reg == ST_SRUN && left_reg == $past(left_reg) - 3'h1)
    else $error("slow bytes not back to back");

  slow_end_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_SRUN && SLOW_DONE && left_reg <= 3'h1 |=>
      state_reg == ST_S4 ##1 CPU_DONE)
    else $error("slow cycle did not end on last byte");

  wait_step_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_S2 && hit_reg && cnt_reg != CST_WAIT_EXT && cnt_reg != CST_CNT_RST &&
      !ext_ack |=> state_reg == ST_S2 && cnt_reg == $past(cnt_reg) - 4'h1)
    else $error("wait state count wrong");

  ext_wait_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_S2 && cnt_reg == CST_WAIT_EXT && !ext_ack |=> state_reg == ST_S2)
    else $error("external wait ended without ack");

  write_hold_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_S4 && !read_reg |=> DATA_OE && $stable(DATA_OUT) && ADDRESS_STROBE_N)
    else $error("write data not held in S5");

  read_strobe_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_S1 && read_reg |-> !ADDRESS_STROBE_N && !DATA_STROBE_N)
    else $error("read strobes missing in S1");

  fetch_s0_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_S0 |-> ADDR_OUT == $past(CPU_ADDR) && READ_OUT == $past(CPU_READ) &&
      FUNC_CODE_OUT == $past(CPU_FUNC_CODE) && SIZE_OUT == $past(CPU_SIZE))
    else $error("S0 address or controls wrong");

  idle_quiet_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_IDLE |-> CS_N && ADDRESS_STROBE_N && DATA_STROBE_N &&
      !BYTE_ACK && !WORD_ACK)
    else $error("bus active while idle");

  sel_s1_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_S1 && CS_MATCH && lane_ok && !SYNC_MODE &&
      (!STROBE_SELECT || read_reg) |-> !CS_N)
    else $error("select not asserted with strobe");

  ack_pulse_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    BYTE_ACK || WORD_ACK |=> !BYTE_ACK && !WORD_ACK && CPU_DONE)
    else $error("ack longer than one cycle");

  lane_lo_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_S1 && port16 && BYTE_FIELD == CST_BYTE_LO && addr_reg[0] |-> CS_N)
    else $error("lower-byte select on upper byte");

  lane_hi_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_S1 && port16 && BYTE_FIELD == CST_BYTE_HI && !addr_reg[0] |-> CS_N)
    else $error("upper-byte select on lower byte");

  lane_word_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_S1 && size_reg != CST_SIZE_BYTE && !addr_reg[0] |-> LANE_UPPER && LANE_LOWER)
    else $error("word access missing a byte lane");

endmodule

// ==== bench/cst_mem_model.sv ====
module cst_mem_model (
  input  wire logic        clk,
  input  wire logic        as_n,
  input  wire logic        cs_n,
  input  wire logic        rd,
  input  wire logic [23:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        oe,
  input  wire logic [31:0] ack_dly,
  output logic             ack_n,
  output logic [15:0]      rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  int          cnt;
  logic [15:0] last_wr;
  initial begin
    cnt = 0;
    last_wr = 16'h0000;
    rdata = 16'hffff;
  end
  // external acknowledge after a set count of strobe cycles, none when zero
  always @(posedge clk) cnt <= as_n ? 0 : cnt + 1;
  assign ack_n = !(ack_dly != 0 && cnt >= ack_dly);
  // read data while selected, ready by S4, then released and toggling
  always @(posedge clk) rdata <= (!cs_n && rd) ? addr[15:0] ^ 16'ha5c3 : ~rdata;
  // latch write data while it is driven
  always @(posedge clk) if (!cs_n && oe && !rd) last_wr <= wdata;
endmodule

// ==== bench/tb_chip_select_termination.sv ====
module tb_chip_select_termination import cst_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, arst_n, req, rd, match, sync, strobe_select_field, ready, sdone;
  logic        ro, as_n, ds_n, cs_n, pend, bya, wda, lu, ll, oe, done, eack_n;
  logic        csn, dsn, ab, aw, pn, gap, ro_s;
  logic [1:0]  size, pin, bytef, lanes, so, so_s;
  logic [2:0]  fc, fo, fo_s;
  logic [3:0]  waitf, st;
  logic [15:0] wdata, din, dout, rdd;
  logic [23:0] addr, ao;
  logic [31:0] seed = 32'h7b69c221;
  int          dly, k, np, num_errors, comparisons, i;

  cst_top cst_top_i (.CLK_SYS(clk), .ARST_N(arst_n), .CPU_REQ(req), .CPU_ADDR(addr),
    .CPU_FUNC_CODE(fc), .CPU_READ(rd), .CPU_SIZE(size), .CPU_WDATA(wdata),
    .CS_MATCH(match), .PIN_FIELD(pin), .WAIT_FIELD(waitf), .BYTE_FIELD(bytef),
    .SYNC_MODE(sync), .STROBE_SELECT(strobe_select_field), .EXT_BYTE_ACK_N(eack_n | pin[0]),
    .EXT_WORD_ACK_N(eack_n | ~pin[0]),
    .SLOW_READY(ready), .SLOW_DONE(sdone), .DATA_IN(din), .ADDR_OUT(ao),
    .FUNC_CODE_OUT(fo), .READ_OUT(ro), .SIZE_OUT(so), .ADDRESS_STROBE_N(as_n),
    .DATA_STROBE_N(ds_n), .CS_N(cs_n), .SLOW_PENDING(pend), .BYTE_ACK(bya),
    .WORD_ACK(wda), .LANE_UPPER(lu), .LANE_LOWER(ll), .DATA_OUT(dout), .DATA_OE(oe),
    .RD_DATA(rdd), .CPU_DONE(done), .BUS_STATE(st));
  cst_mem_model cst_mem_model_i (.clk(clk), .as_n(as_n), .cs_n(cs_n), .rd(ro), .addr(ao),
    .wdata(dout), .oe(oe), .ack_dly(dly), .ack_n(eack_n), .rdata(din));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic summarize();
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // one request from take edge to completion, sampling at falling edges
  task automatic run(input logic r, input logic [31:0] a, input logic [1:0] sz);
    req = 1;
    rd = r;
    addr = a[23:0];
    size = sz;
    wdata = 16'(rnd());
    fc = 3'(rnd());
    k = 0;
    {csn, dsn, ab, aw, pn, gap, np} = '0;
    while (k < 60) begin
      @(negedge clk);
      k++;
      np += int'(sdone);
      ready = k >= 5;
      sdone = sync && !cs_n && k % 3 == 0;
      ab |= bya;
      aw |= wda;
      pn |= pend && !csn;
      if (st === 4'h2) {lanes, ro_s, fo_s, so_s} = {lu, ll, ro, fo, so};
      if (done) break;
      gap |= csn && cs_n && st !== 4'h6;
      csn |= !cs_n;
      dsn |= !ds_n;
    end
    req = 0;
    sdone = 0;
    if (k >= 60) begin
      num_errors++;
      summarize();
    end
    @(negedge clk);
  endtask

  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end

  initial begin
    {arst_n, req, rd, sync, strobe_select_field, ready, sdone, size, wdata, addr, dly, fc} = '0;
    {match, pin, bytef, waitf} = {1'b1, 2'h3, 2'h3, CST_WAIT_FAST};
    num_errors = 0;
    comparisons = 0;
    repeat (20) @(negedge clk);
    arst_n = 1;
    @(negedge clk);
    // fast cycles over every pin encoding, reads and writes
    // one select only, so no overlapping wait fields to agree
    for (i = 0; i < 8; i++) begin
      pin = i[1:0];
      run(i[2], rnd(), seed[25:24]);
      chk("cycles", 4, k);
      chk("acks", {!pin[0], pin[0]}, {ab, aw});
      chk("lanes", {!addr[0], addr[0] | (size != CST_SIZE_BYTE)}, lanes);
      chk("dir", rd, ro_s);
      chk("code", {fc, size}, {fo_s, so_s});
      chk("select", 1, csn);
      chk("dstrobe", rd, dsn);
      if (rd) chk("rdata", addr[15:0] ^ 16'ha5c3, rdd);
      else chk("wdata", wdata, cst_mem_model_i.last_wr);
    end
    // byte field gating on a 16-bit port
    dly = 5;
    for (i = 0; i < 8; i++) begin
      bytef = i[1:0];
      run(1, (rnd() & 32'hfffffffe) | 32'(i[2]), 2'h2);
      chk("bytesel", bytef[i[2]], csn);
      chk("wordack", bytef[i[2]], aw);
    end
    bytef = 2'h3;
    dly = 0;
    for (i = 0; i < 6; i++) begin
      waitf = (i == 0) ? 4'h0 : 4'(rnd() % 14);
      run(1, rnd(), 2'h2);
      chk("waitcyc", waitf + 5, k);
    end
    waitf = 4'hd;
    dly = 3;
    run(1, rnd(), 2'h2);
    chk("early", 1, k < 18);
    waitf = CST_WAIT_EXT;
    dly = 7;
    run(0, rnd(), 2'h2);
    chk("extwait", 1, k > 7 && !(ab | aw));
    waitf = CST_WAIT_FAST;
    match = 0;
    run(1, rnd(), 2'h2);
    chk("missack", 0, ab | aw);
    match = 1;
    strobe_select_field = 1;
    run(0, rnd(), 2'h2);
    chk("wrsel", 0, csn);
    strobe_select_field = 0;
    // slow-clock synchronized byte-port cycles of each size
    // no autovector is ever requested on these selects
    sync = 1;
    pin = 2'h0;
    dly = 0;
    for (i = 0; i < 4; i++) begin
      waitf = 4'(rnd());
      run(i[0], rnd(), i[1:0]);
      chk("slowbytes", i == 0 ? 4 : i, np);
      chk("pending", 1, pn);
      chk("slowgap", 0, gap);
      chk("slowcyc", 3 * (i == 0 ? 4 : i) + 5, k);
      chk("slowack", 0, ab | aw);
    end
    summarize();
  end
endmodule
